//--- verilog/rts_sequencer.sv
// Reset time-out sequencer and reset cause recorder.
// Assumes Avalon-MM register access, synchronous tick inputs for the
// low-frequency and external oscillators, and a core that obeys cpu_hold.
`timescale 1ns/1ps
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int POWER_UP_TIMER_TICKS = RTS_POWER_UP_TIMER_TICKS,
  parameter int OST_TICKS = RTS_OST_TICKS,
  parameter int PLL_CYCLES = RTS_PLL_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset sources and events
  input wire logic por_pulse,
  input wire logic brown_out,
  input wire logic external_reset_pin_n,
  input wire logic wdt_timeout,
  input wire logic reset_instr,
  input wire logic stack_full_evt,
  input wire logic stack_underflow_evt,
  input wire logic int_wake,
  // Clock ticks
  input wire logic low_freq_tick,
  input wire logic osc_tick,
  // Configuration and context
  input wire rts_osc_t osc_mode,
  input wire logic power_up_timer_enable_n,
  input wire logic [1:0] brownout_config,
  input wire logic stack_overflow_reset_enable,
  input wire logic global_int_enable_high,
  input wire logic global_int_enable_low,
  input wire rts_pm_t pm_mode,
  input wire logic [20:0] current_pc,
  // Outputs to the core
  output logic cpu_hold,
  output logic brownout_active,
  output logic restart_valid,
  output logic [20:0] restart_pc,
  output rts_kind_t reset_kind
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rts_state_t state_r; // Sequencer state
  logic [RTS_CNT_W-1:0] cnt_r; // Shared delay counter
  rts_flags_t flags_r; // Reset cause flags
  logic ack_r; // Bus answer phase
  logic pin_d_r; // Delayed reset pin
  logic restart_valid_r; // Restart pulse
  logic [20:0] restart_pc_r; // Restart address
  rts_kind_t reset_kind_r; // Kind of last restart
  logic crystal; // Mode uses start-up count
  logic pll_mode; // PLL in use
  logic bor_eff; // Effective brown-out
  logic pin_fall; // Reset pin asserted
  logic pin_rise; // Reset pin released
  logic pm_low; // Idle or sleep
  logic running; // Sequencer released
  logic bus_wr; // Write takes effect
  logic wr_reset_control_register; // Write to flag register
  logic wr_stk; // Write to stack flags
  logic wake_evt; // Wake without reset
  logic software_brownout_enable_read; // Visible software enable

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Crystal family modes
  assign crystal = (osc_mode == RTS_LP) || (osc_mode == RTS_XT) ||
                   (osc_mode == RTS_HS) || (osc_mode == RTS_HIGH_SPEED_CRYSTAL_PLL_MODE);
  assign pll_mode = (osc_mode == RTS_HIGH_SPEED_CRYSTAL_PLL_MODE);
  assign pm_low = (pm_mode == RTS_PM_IDLE) || (pm_mode == RTS_PM_SLEEP);
  assign running = (state_r == RTS_ST_RUN);
  assign pin_fall = pin_d_r && !external_reset_pin_n;
  assign pin_rise = !pin_d_r && external_reset_pin_n;
  // Software enable reads as zero unless software control selected
  assign software_brownout_enable_read = (brownout_config == RTS_BOR_SW) && flags_r.software_brownout_enable;

  // Brown-out detector gating by configuration and software enable
  always_comb
  begin
    brownout_active = 1'b1;
    if (brownout_config == RTS_BOR_OFF)
    begin
      brownout_active = 1'b0;
    end
    else if (brownout_config == RTS_BOR_SW)
    begin
      brownout_active = flags_r.software_brownout_enable;
    end
    else if (brownout_config == RTS_BOR_NOSLEEP)
    begin
      brownout_active = (pm_mode != RTS_PM_SLEEP);
    end
  end
  assign bor_eff = brown_out && brownout_active;

  // Wake events that resume instead of resetting
  assign wake_evt = running && ((wdt_timeout && pm_low) || int_wake);

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then answer
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign bus_wr = avs_write && ack_r;
  assign wr_reset_control_register = bus_wr && (avs_address == RTS_ADDR_RESET_CONTROL_REGISTER);
  assign wr_stk = bus_wr && (avs_address == RTS_ADDR_STACK_POINTER_REGISTER);

  // Answer phase toggles once per request
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        RTS_ADDR_RESET_CONTROL_REGISTER:
          avs_readdata <= {25'h0000000, software_brownout_enable_read, 1'b0, flags_r.ri, flags_r.to,
                           flags_r.pd, flags_r.por, flags_r.bor};
        RTS_ADDR_STACK_POINTER_REGISTER:
          avs_readdata <= {24'h000000, flags_r.stack_full_flag, flags_r.stack_underflow_flag, 6'h00};
        RTS_ADDR_STATUS:
          avs_readdata <= {27'h0000000, cpu_hold, 1'b0, state_r};
        default:
          avs_readdata <= 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  // ****************************************************************
  // Time-out sequencer
  // ****************************************************************
  // Power-on and brown-out restart the whole sequence
  always_ff @(posedge clk_sys)
  begin
    if (reset || por_pulse || bor_eff)
    begin
      state_r <= RTS_ST_POR;
      cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        RTS_ST_POR:
        begin
          cnt_r <= '0;
          if (!power_up_timer_enable_n)
            state_r <= RTS_ST_POWER_UP_TIMER;
          else if (crystal)
            state_r <= RTS_ST_OST;
          else
            state_r <= RTS_ST_RUN;
        end
        RTS_ST_POWER_UP_TIMER:
        begin
          // 11-bit count of low-frequency ticks
          if (low_freq_tick)
          begin
            if (cnt_r == RTS_CNT_W'(POWER_UP_TIMER_TICKS - 1))
            begin
              cnt_r <= '0;
              state_r <= crystal ? RTS_ST_OST : RTS_ST_RUN;
            end
            else
              cnt_r <= cnt_r + 1'b1;
          end
        end
        RTS_ST_OST:
        begin
          if (osc_tick)
          begin
            if (cnt_r == RTS_CNT_W'(OST_TICKS - 1))
            begin
              cnt_r <= '0;
              state_r <= pll_mode ? RTS_ST_PLL : RTS_ST_RUN;
            end
            else
              cnt_r <= cnt_r + 1'b1;
          end
        end
        RTS_ST_PLL:
        begin
          if (cnt_r == RTS_CNT_W'(PLL_CYCLES - 1))
          begin
            cnt_r <= '0;
            state_r <= RTS_ST_RUN;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        RTS_ST_RUN:
        begin
          cnt_r <= '0;
          // Sleep stopped the oscillator: wait again, timer skipped
          if (wake_evt && pm_mode == RTS_PM_SLEEP && crystal)
            state_r <= RTS_ST_OST;
        end
        default:
        begin
          state_r <= RTS_ST_POR;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Core held while sequencing or while the pin is low
  assign cpu_hold = !running || !external_reset_pin_n;

  // Pin history for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pin_d_r <= 1'b1;
    else
      pin_d_r <= external_reset_pin_n;
  end

  // ****************************************************************
  // Reset cause flags; hardware events win over software writes
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      flags_r <= RTS_FLAGS_POR;
    end
    else
    begin
      // Software writes first
      if (wr_reset_control_register)
      begin
        flags_r.ri <= avs_writedata[RTS_BIT_RI];
        flags_r.por <= avs_writedata[RTS_BIT_POR];
        flags_r.bor <= avs_writedata[RTS_BIT_BOR];
        if (brownout_config == RTS_BOR_SW)
          flags_r.software_brownout_enable <= avs_writedata[RTS_BIT_SOFTWARE_BROWNOUT_ENABLE];
      end
      if (wr_stk)
      begin
        flags_r.stack_full_flag <= avs_writedata[RTS_BIT_STACK_FULL_FLAG];
        flags_r.stack_underflow_flag <= avs_writedata[RTS_BIT_STACK_UNDERFLOW_FLAG];
      end
      // Hardware events override
      if (por_pulse)
      begin
        flags_r <= RTS_FLAGS_POR;
        flags_r.software_brownout_enable <= (brownout_config == RTS_BOR_SW);
      end
      else if (bor_eff)
      begin
        flags_r.ri <= 1'b1;
        flags_r.to <= 1'b1;
        flags_r.pd <= 1'b1;
        flags_r.bor <= 1'b0;
      end
      else if (running)
      begin
        if (reset_instr)
          flags_r.ri <= 1'b0;
        else if (pin_fall && pm_mode == RTS_PM_RUN)
          flags_r.to <= 1'b1;
        else if (pin_fall && pm_low)
        begin
          flags_r.to <= 1'b1;
          flags_r.pd <= 1'b0;
        end
        else if (pin_fall)
          ; // Full power: flags kept
        else if (wdt_timeout && pm_low)
        begin
          flags_r.to <= 1'b0;
          flags_r.pd <= 1'b0;
        end
        else if (wdt_timeout)
          flags_r.to <= 1'b0;
        else if (int_wake)
          flags_r.pd <= 1'b0;
        else if (stack_full_evt && stack_overflow_reset_enable)
          flags_r.stack_full_flag <= 1'b1;
        else if (stack_underflow_evt)
          flags_r.stack_underflow_flag <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Restart address and kind
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      restart_valid_r <= 1'b0;
      restart_pc_r <= RTS_PC_RESET;
      reset_kind_r <= RTS_RK_NONE;
    end
    else
    begin
      restart_valid_r <= 1'b0;
      if (por_pulse || bor_eff)
      begin
        restart_pc_r <= RTS_PC_RESET;
        reset_kind_r <= RTS_RK_COLD;
      end
      else if (state_r != RTS_ST_RUN)
      begin
        ; // Sequencer busy
      end
      else if (pin_rise)
      begin
        restart_valid_r <= 1'b1;
        restart_pc_r <= RTS_PC_RESET;
        reset_kind_r <= RTS_RK_WARM;
      end
      else if (wake_evt)
      begin
        restart_valid_r <= 1'b1;
        reset_kind_r <= RTS_RK_WAKE;
        if (int_wake && !(wdt_timeout && pm_low) && global_int_enable_high)
          restart_pc_r <= RTS_VEC_HIGH;
        else if (int_wake && !(wdt_timeout && pm_low) && global_int_enable_low)
          restart_pc_r <= RTS_VEC_LOW;
        else
          restart_pc_r <= current_pc + RTS_PC_STEP;
      end
      else if (reset_instr || wdt_timeout ||
               ((stack_full_evt || stack_underflow_evt) && stack_overflow_reset_enable))
      begin
        restart_valid_r <= 1'b1;
        restart_pc_r <= RTS_PC_RESET;
        reset_kind_r <= RTS_RK_WARM;
      end
    end
  end

  assign restart_valid = restart_valid_r;
  assign restart_pc = restart_pc_r;
  assign reset_kind = reset_kind_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  por_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
    por_pulse |=> (flags_r.ri && flags_r.to && flags_r.pd && !flags_r.por &&
                   !flags_r.bor && !flags_r.stack_full_flag && !flags_r.stack_underflow_flag &&
                   state_r == RTS_ST_POR))
    else $error("power-on flags wrong");

  power_up_timer_end_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == RTS_ST_POWER_UP_TIMER && low_freq_tick && !por_pulse && !bor_eff &&
     cnt_r == RTS_CNT_W'(POWER_UP_TIMER_TICKS - 1)) |=> state_r != RTS_ST_POWER_UP_TIMER)
    else $error("power-up timer overran");

  ost_crystal_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(state_r == RTS_ST_OST) |-> crystal)
    else $error("start-up count in non-crystal mode");

  rc_nodelay_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == RTS_ST_POR && !por_pulse && !bor_eff && osc_mode == RTS_RC &&
     power_up_timer_enable_n) |=> running)
    else $error("RC mode delayed");

  hold_seq_a: assert property (@(posedge clk_sys) disable iff (reset)
    !running |-> cpu_hold)
    else $error("core released early");

  pin_full_a: assert property (@(posedge clk_sys) disable iff (reset)
    (running && pin_fall && pm_mode == RTS_PM_FULL && !por_pulse && !bor_eff &&
     !reset_instr && !bus_wr) |=> flags_r == $past(flags_r))
    else $error("flags changed on pin in full power");

  wdt_sleep_a: assert property (@(posedge clk_sys) disable iff (reset)
    (running && wdt_timeout && pm_low && !pin_fall && !pin_rise && !reset_instr &&
     !por_pulse && !bor_eff) |=> (!flags_r.to && !flags_r.pd && restart_valid &&
     restart_pc == $past(current_pc) + RTS_PC_STEP))
    else $error("watchdog wake wrong");

  por_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!flags_r.por && !wr_reset_control_register) |=> !flags_r.por)
    else $error("power-on flag set by hardware");

  stk_full_a: assert property (@(posedge clk_sys) disable iff (reset)
    (running && stack_full_evt && stack_overflow_reset_enable && !reset_instr &&
     !pin_fall && !wdt_timeout && !int_wake && !por_pulse && !bor_eff)
    |=> (flags_r.stack_full_flag && restart_valid && restart_pc == RTS_PC_RESET))
    else $error("stack full reset wrong");

  pll_after_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == RTS_ST_OST ##1 state_r == RTS_ST_PLL) |-> pll_mode)
    else $error("lock delay outside PLL mode");

endmodule // rts_sequencer

//--- verilog/rts_pkg.sv
// Constants, types and register map of the reset and start-up sequencer.
// Assumes a single 10 MHz system clock; all inputs arrive synchronous to it.
package rts_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RTS_CLK_PERIOD_NS = 100; // System clock period
  localparam int RTS_PLL_LOCK_NS = 2000000; // PLL lock delay, 2 ms
  localparam int RTS_PLL_CYCLES = RTS_PLL_LOCK_NS / RTS_CLK_PERIOD_NS; // Longest time, round down
  localparam int RTS_POWER_UP_TIMER_TICKS = 2048; // 11-bit timer, about 66 ms
  localparam int RTS_OST_TICKS = 1024; // Oscillator periods
  localparam int RTS_CNT_W = 15; // Shared delay counter width

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] RTS_ADDR_RESET_CONTROL_REGISTER = 4'h0; // reset_control_register
  localparam logic [3:0] RTS_ADDR_STACK_POINTER_REGISTER = 4'h4; // stack_pointer_register flags
  localparam logic [3:0] RTS_ADDR_STATUS = 4'h8; // Sequencer state
  localparam int RTS_BIT_SOFTWARE_BROWNOUT_ENABLE = 6;
  localparam int RTS_BIT_RI = 4;
  localparam int RTS_BIT_TO = 3;
  localparam int RTS_BIT_PD = 2;
  localparam int RTS_BIT_POR = 1;
  localparam int RTS_BIT_BOR = 0;
  localparam int RTS_BIT_STACK_FULL_FLAG = 7;
  localparam int RTS_BIT_STACK_UNDERFLOW_FLAG = 6;

  // ****************************************************************
  // Addresses and configuration codes
  // ****************************************************************
  localparam logic [20:0] RTS_PC_RESET = 21'h000000;
  localparam logic [20:0] RTS_VEC_HIGH = 21'h000008;
  localparam logic [20:0] RTS_VEC_LOW = 21'h000018;
  localparam logic [20:0] RTS_PC_STEP = 21'h000002;
  localparam logic [1:0] RTS_BOR_SW = 2'h1; // Software brown-out control
  localparam logic [1:0] RTS_BOR_NOSLEEP = 2'h2; // Off during sleep
  localparam logic [1:0] RTS_BOR_OFF = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    RTS_LP = 3'h0, RTS_XT = 3'h1, RTS_HS = 3'h2, RTS_HIGH_SPEED_CRYSTAL_PLL_MODE = 3'h3,
    RTS_EC = 3'h4, RTS_RC = 3'h5, RTS_INTOSC = 3'h6
  } rts_osc_t;

  typedef enum logic [1:0] {
    RTS_PM_FULL = 2'h0, RTS_PM_RUN = 2'h1, RTS_PM_IDLE = 2'h2, RTS_PM_SLEEP = 2'h3
  } rts_pm_t;

  typedef enum logic [2:0] {
    RTS_ST_POR = 3'h0, RTS_ST_POWER_UP_TIMER = 3'h1, RTS_ST_OST = 3'h2,
    RTS_ST_PLL = 3'h3, RTS_ST_RUN = 3'h4
  } rts_state_t;

  typedef enum logic [1:0] {
    RTS_RK_NONE = 2'h0, RTS_RK_COLD = 2'h1, RTS_RK_WARM = 2'h2, RTS_RK_WAKE = 2'h3
  } rts_kind_t;

  // Reset cause flags
  typedef struct packed {
    logic software_brownout_enable;
    logic ri;
    logic to;
    logic pd;
    logic por;
    logic bor;
    logic stack_full_flag;
    logic stack_underflow_flag;
  } rts_flags_t;

  localparam rts_flags_t RTS_FLAGS_POR = 8'hF0; // software_brownout_enable,ri,to,pd = 1

endpackage

//--- dv/tb.sv
// Self-checking bench for the reset sequencer: start-up waits, flags, restarts.
// Assumes rts_pkg is compiled first; the bench drives every input.
`timescale 1ns/1ps
module tb;
  import rts_pkg::*;
  // ********************
  // Signals
  // ********************
  localparam int PW = 4; // Shortened power-up timer
  localparam int OS = 4; // Shortened oscillator count
  localparam int PL = 8; // Shortened PLL lock wait
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h53;
  logic avs_waitrequest, cpu_hold, brownout_active, restart_valid;
  logic por_pulse = 1'b0, brown_out = 1'b0, external_reset_pin_n = 1'b1;
  logic wdt_timeout = 1'b0, reset_instr = 1'b0, stack_full_evt = 1'b0;
  logic stack_underflow_evt = 1'b0, int_wake = 1'b0, low_freq_tick = 1'b0;
  logic osc_tick = 1'b0, power_up_timer_enable_n = 1'b1;
  logic [1:0] brownout_config = 2'h1;
  logic stack_overflow_reset_enable = 1'b0;
  logic global_int_enable_high = 1'b0, global_int_enable_low = 1'b0;
  logic [20:0] current_pc = 21'h0, restart_pc, rs_pc;
  rts_osc_t osc_mode = RTS_EC;
  rts_pm_t pm_mode = RTS_PM_FULL;
  rts_kind_t reset_kind, rs_kind;
  logic e_sb, e_ri, e_to, e_pd, e_por, e_bor, e_sf, e_su; // Expected flags
  int errors = 0, n_tests = 0, rs_cnt = 0;
  // Hand-picked events: kind, power mode, option
  int tk[13] = '{0, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 5, 5};
  int tp[13] = '{0, 0, 1, 2, 1, 3, 2, 3, 2, 0, 0, 0, 0};
  int tq[13] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 1, 0, 0, 1};

  rts_sequencer #(.POWER_UP_TIMER_TICKS(PW), .OST_TICKS(OS), .PLL_CYCLES(PL)) dut_u (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .por_pulse, .brown_out, .external_reset_pin_n,
    .wdt_timeout, .reset_instr, .stack_full_evt, .stack_underflow_evt, .int_wake,
    .low_freq_tick, .osc_tick, .osc_mode, .power_up_timer_enable_n, .brownout_config,
    .stack_overflow_reset_enable, .global_int_enable_high, .global_int_enable_low,
    .pm_mode, .current_pc, .cpu_hold, .brownout_active, .restart_valid, .restart_pc,
    .reset_kind
  );

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // Records every restart pulse
  always @(posedge clk_sys)
  begin
    if (restart_valid === 1'b1)
    begin
      rs_cnt <= rs_cnt + 1;
      rs_pc <= restart_pc;
      rs_kind <= reset_kind;
    end
  end

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] reset_control_register_x();
    return {25'h0, e_sb, 1'b0, e_ri, e_to, e_pd, e_por, e_bor};
  endfunction

  function automatic logic [31:0] stk_x();
    return {24'h0, e_sf, e_su, 6'h0};
  endfunction

  task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] got);
    n_tests++;
    if (got !== x)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic x, input logic got);
    n_tests++;
    if (got !== x)
    begin
      errors++;
      $display("Error %s expected %b seen %b", nm, x, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One bus word; holds the request until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(negedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 40)
    begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 40)
      errors++;
    @(posedge clk_sys);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] x, input string nm);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk_word(nm, x, d);
  endtask

  // Software write of the reset flags; the timeout and power-down bits stay
  task automatic wr_reset_control_register(input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, RTS_ADDR_RESET_CONTROL_REGISTER, d, q);
    e_sb = d[6] & (brownout_config == RTS_BOR_SW);
    {e_ri, e_por, e_bor} = {d[4], d[1], d[0]};
  endtask

  task automatic drive(input int k, input logic v);
    case (k)
      0: reset_instr <= v;
      1: external_reset_pin_n <= !v;
      2: wdt_timeout <= v;
      3: int_wake <= v;
      4: stack_full_evt <= v;
      5: stack_underflow_evt <= v;
      6: brown_out <= v;
      8: osc_tick <= v;
      default: por_pulse <= v;
    endcase
  endtask

  task automatic pulse(input int k, input int len);
    @(posedge clk_sys);
    drive(k, 1'b1);
    repeat (len) @(posedge clk_sys);
    drive(k, 1'b0);
  endtask

  task automatic hold_chk(input logic x);
    @(negedge clk_sys);
    chk_bit("cpu_hold", x, cpu_hold);
  endtask

  // Bounded wait for the core to be let go
  task automatic hold_fall();
    int k;
    k = 0;
    while (cpu_hold !== 1'b0 && k < 20)
    begin
      k++;
      @(negedge clk_sys);
    end
    chk_bit("cpu_hold_end", 1'b0, cpu_hold);
  endtask

  // ********************
  // Scenarios
  // ********************
  // Power-on: timer ticks first, oscillator ticks only count afterwards
  task automatic power_up(input rts_osc_t m, input logic pen_n, input logic pin_low);
    logic [31:0] r;
    @(posedge clk_sys);
    osc_mode <= m;
    power_up_timer_enable_n <= pen_n;
    external_reset_pin_n <= !pin_low;
    pulse(9, 3);
    repeat (3) @(posedge clk_sys);
    if (pen_n && m > RTS_HIGH_SPEED_CRYSTAL_PLL_MODE && !pin_low)
      hold_chk(1'b0);
    for (int i = 0; i < PW && !pen_n; i++)
    begin
      hold_chk(1'b1);
      r = xs();
      @(posedge clk_sys);
      low_freq_tick <= 1'b1;
      osc_tick <= (i < PW - 1) && r[0];
      @(posedge clk_sys);
      low_freq_tick <= 1'b0;
      osc_tick <= 1'b0;
      repeat (r[2:1]) @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < OS && m <= RTS_HIGH_SPEED_CRYSTAL_PLL_MODE; i++)
    begin
      hold_chk(1'b1);
      pulse(8, 1);
      repeat (xs() % 3) @(posedge clk_sys);
    end
    if (m == RTS_HIGH_SPEED_CRYSTAL_PLL_MODE)
    begin
      repeat (PL - 3) @(posedge clk_sys);
      hold_chk(1'b1);
    end
    if (pin_low)
    begin
      repeat (20) @(posedge clk_sys);
      hold_chk(1'b1);
      @(posedge clk_sys);
      external_reset_pin_n <= 1'b1;
      hold_chk(1'b0);
    end
    hold_fall();
  endtask

  // One reset or wake event; the model predicts flags and restart address
  task automatic ev(input int k, input int pm, input int opt);
    int c0;
    logic rs;
    logic [20:0] pc, epc;
    rts_kind_t ek;
    pc = 21'(xs()) & 21'h1FFFFE;
    if (k == 3)
      pm = pm | 2;
    rs = 1'b1;
    epc = RTS_PC_RESET;
    ek = RTS_RK_WARM;
    case (k)
      0: e_ri = 1'b0;
      1:
      begin
        e_to = (pm > 0) ? 1'b1 : e_to;
        e_pd = (pm > 1) ? 1'b0 : e_pd;
      end
      2:
      begin
        e_to = 1'b0;
        e_pd = (pm > 1) ? 1'b0 : e_pd;
        epc = (pm > 1) ? pc + RTS_PC_STEP : RTS_PC_RESET;
        ek = (pm > 1) ? RTS_RK_WAKE : RTS_RK_WARM;
      end
      3:
      begin
        e_pd = 1'b0;
        ek = RTS_RK_WAKE;
        epc = (opt == 1) ? RTS_VEC_HIGH : (opt == 2) ? RTS_VEC_LOW : pc + RTS_PC_STEP;
      end
      4:
      begin
        rs = (opt != 0);
        e_sf = e_sf | rs;
      end
      5:
      begin
        rs = (opt != 0);
        e_su = 1'b1;
      end
      default: {e_ri, e_to, e_pd, e_bor} = 4'hE;
    endcase
    @(posedge clk_sys);
    pm_mode <= rts_pm_t'(pm);
    current_pc <= pc;
    global_int_enable_high <= (opt == 1);
    global_int_enable_low <= (opt == 2);
    stack_overflow_reset_enable <= (opt != 0);
    c0 = rs_cnt;
    pulse(k, (k == 1 || k == 6) ? 3 : 1);
    repeat (8) @(posedge clk_sys);
    if (k != 6)
      chk_word("restart_count", 32'(c0 + rs), 32'(rs_cnt));
    if (rs && k != 6)
    begin
      chk_word("restart_pc", {11'h0, epc}, {11'h0, rs_pc});
      chk_word("restart_kind", 32'(ek), 32'(rs_kind));
    end
    rd_chk(RTS_ADDR_RESET_CONTROL_REGISTER, reset_control_register_x(), "reset_control_register");
    rd_chk(RTS_ADDR_STACK_POINTER_REGISTER, stk_x(), "stack_flags");
    hold_chk(1'b0);
    wr_reset_control_register(32'h53);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int m = 0; m < 7; m++)
      for (int p = 0; p < 2; p++)
        power_up(rts_osc_t'(m), p[0], m == 2 && p == 0);
    // Wake from sleep in a crystal mode: oscillator wait only, no timer
    power_up(RTS_HS, 1'b0, 1'b0);
    @(posedge clk_sys);
    pm_mode <= RTS_PM_SLEEP;
    pulse(3, 1);
    hold_chk(1'b1);
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < OS; i++)
      pulse(8, 1);
    hold_fall();
    power_up(RTS_EC, 1'b1, 1'b0);
    {e_sb, e_ri, e_to, e_pd, e_por, e_bor, e_sf, e_su} = {1'b1, 7'h70};
    rd_chk(RTS_ADDR_RESET_CONTROL_REGISTER, reset_control_register_x(), "reset_control_register_por");
    rd_chk(RTS_ADDR_STACK_POINTER_REGISTER, stk_x(), "stack_por");
    rd_chk(4'hC, 32'h0, "unmapped");
    rd_chk(RTS_ADDR_STATUS, 32'h4, "status_run");
    wr_reset_control_register(32'h53);
    rd_chk(RTS_ADDR_RESET_CONTROL_REGISTER, reset_control_register_x(), "reset_control_register_sw");
    ev(6, 0, 0);
    for (int i = 0; i < 13; i++)
      ev(tk[i], tp[i], tq[i]);
    for (int i = 0; i < 12; i++)
      ev(xs() % 7, xs() % 4, xs() % 3);
    // Software brown-out switched off: the detector is ignored
    wr_reset_control_register(32'h13);
    @(negedge clk_sys);
    chk_bit("brownout_active", 1'b0, brownout_active);
    pulse(6, 3);
    repeat (8) @(posedge clk_sys);
    rd_chk(RTS_ADDR_RESET_CONTROL_REGISTER, reset_control_register_x(), "reset_control_register_bo_off");
    // Hardware control that drops out in sleep
    @(posedge clk_sys);
    brownout_config <= 2'h2;
    pm_mode <= RTS_PM_SLEEP;
    @(negedge clk_sys);
    chk_bit("brownout_sleep", 1'b0, brownout_active);
    @(posedge clk_sys);
    brownout_config <= 2'h3;
    wr_reset_control_register(32'h53);
    ev(0, 0, 0);
    tally_and_finish();
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
endmodule // tb
